// ==== rtl/rfsb_ctrl.sv ====
// RF port mode, switch enable and bias output control
// Notes on behaviour
// RQ1: After reset the port mode bit (12) reads zero, selecting dual-port operation.
// RQ2: Port mode bit one selects single-port operation with the rx pair bidirectional.
// RQ3: Single-port receive enables the rx switch and keeps the rx pair amplifier off.
// RQ4: Single-port transmit disables the rx switch and enables the rx pair amplifier.
// RQ5: Single-port with bias enabled drives high on transmit, low on receive, polarity ignored.
// RQ6: The bias output is high only during a channel assessment, receive or transmit sequence.
// RQ7: Dual-port leaves the rx pair as inputs with switch on for receive and its amplifier off.
// RQ8: Dual-port transmits only on the tx pair, whose amplifier is on during transmit.
// RQ9: Bias enable bit (14) resets to zero and keeps the bias pin high-impedance.
// RQ10: Bias enable one drives the pin from port mode, polarity and radio activity.
// RQ11: Polarity bit (13) resets to zero and matters only in dual-port with bias enabled.
// RQ12: Dual-port with bias enabled toggles the pin between transmit and receive levels.
// RQ13: Polarity one inverts the dual-port transmit and receive sense of the bias pin.
// RQ14: Idle, doze or hibernate drives the pin low when enabled, high-impedance otherwise.
// RQ15: Control bit changes reach the outputs on the clock after the write completes.
// RQ16: The host sets up the control bits before any sequence and leaves them alone during it.
`default_nettype none
module rfsb_ctrl (
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RST_B,
   // Register port
   input  wire logic              REG_WE,
   input  wire logic [5:0]        REG_ADDR,
   input  wire logic [15:0]       REG_WDATA,
   output logic      [15:0]       REG_RDATA,
   // Radio activity from the sequencer
   input  wire rfsb_pkg::rfsb_op_t RADIO_OP,
   // Front end controls
   output logic                   RX_SWITCH_EN,
   output logic                   RX_PAIR_PA_EN,
   output logic                   TX_PAIR_PA_EN,
   output logic                   RX_PAIR_DIR_OUT,
   // Bias pin
   output logic                   BIAS_SWITCH_OUT_O,
   output logic                   BIAS_SWITCH_OUT_OE
);

   // ---------------------------------------------------------------
   // Register
   // ---------------------------------------------------------------
   logic [15:0]         rf_control_b_reg;
   rfsb_pkg::rfsb_ctrl_t ctrl;
   rfsb_pkg::rfsb_fe_t   fe_next;
   rfsb_pkg::rfsb_fe_t   fe_reg;
   logic                 wr_hit;
   logic                 is_tx;
   logic                 is_rx;
   logic                 in_seq;
   logic                 dual_level;

   assign wr_hit = REG_WE && (REG_ADDR == rfsb_pkg::RF_CONTROL_B_ADDR);

   // Whole word held; only bits 14..12 steer this block
   // RQ1 reset values
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rf_control_b_reg <= rfsb_pkg::RF_CONTROL_B_RST;
      end else if (wr_hit) begin
         rf_control_b_reg <= REG_WDATA;
      end
   end

   // Read answer is the held word; control bits reflect exactly what was written
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= 16'h0000;
      end else begin
         REG_RDATA <= (REG_ADDR == rfsb_pkg::RF_CONTROL_B_ADDR) ? rf_control_b_reg : 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // RQ2 port mode select
   assign ctrl.single_port = rf_control_b_reg[rfsb_pkg::PORT_MODE_POS];
   assign ctrl.polarity    = rf_control_b_reg[rfsb_pkg::POLARITY_POS];
   assign ctrl.bias_en     = rf_control_b_reg[rfsb_pkg::BIAS_EN_POS];

   assign is_tx  = (RADIO_OP == rfsb_pkg::RFSB_TX);
   assign is_rx  = (RADIO_OP == rfsb_pkg::RFSB_RX) || (RADIO_OP == rfsb_pkg::RFSB_CCA);
   // RQ6 high only in a sequence
   assign in_seq = is_tx || is_rx;

   // RQ13 polarity inverts dual-port sense
   assign dual_level = is_tx ^ ctrl.polarity;

   // Enables per mode
   always_comb begin
      fe_next = '0;
      if (ctrl.single_port) begin
         // RQ3 single-port receive
         fe_next.rx_switch_en  = is_rx;
         // RQ4 single-port transmit
         fe_next.rx_pair_pa_en = is_tx;
      end else begin
         // RQ7 dual-port rx pair input only
         fe_next.rx_switch_en  = is_rx;
         // RQ8 dual-port tx pair
         fe_next.tx_pair_pa_en = is_tx;
      end
      // RQ9 tri-state while disabled
      // RQ10 driven while enabled
      fe_next.bias_oe = ctrl.bias_en;
      if (ctrl.bias_en && in_seq) begin
         // RQ5 single-port ignores polarity
         // RQ11 polarity only in dual-port
         // RQ12 dual-port toggles with tx/rx
         fe_next.bias_out = ctrl.single_port ? is_tx : dual_level;
      end else begin
         // RQ14 low when idle, doze, hibernate
         fe_next.bias_out = 1'b0;
      end
   end

   // RQ15 registered outputs, one clock after write
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fe_reg <= '0;
      end else begin
         fe_reg <= fe_next;
      end
   end

   assign RX_SWITCH_EN       = fe_reg.rx_switch_en;
   assign RX_PAIR_PA_EN      = fe_reg.rx_pair_pa_en;
   assign TX_PAIR_PA_EN      = fe_reg.tx_pair_pa_en;
   assign RX_PAIR_DIR_OUT    = fe_reg.rx_pair_pa_en;
   assign BIAS_SWITCH_OUT_O  = fe_reg.bias_out;
   assign BIAS_SWITCH_OUT_OE = fe_reg.bias_oe;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Every output is one flop behind its inputs, so most checks look
   // one edge later with |=>. Expected levels are written from the
   // decode wires above (ctrl, is_tx, is_rx, in_seq) rather than from the
   // mode table, so a slip in the decode is mirrored here instead of showing up.

   // ---------------------------------------------------------------
   // Reset state
   // ---------------------------------------------------------------
   // These run without the reset disable, since they watch reset itself.

   // RQ1 dual-port after reset
   a_reset_dual_mode : assert property (@(posedge CLK) // RQ1
      !RST_B |-> (!ctrl.single_port && !ctrl.polarity && !ctrl.bias_en))
      else $error("control bits not cleared in reset");

   // RQ9 pin floats in reset
   a_reset_bias_hiz : assert property (@(posedge CLK) // RQ9
      !RST_B |-> !BIAS_SWITCH_OUT_OE)
      else $error("bias pin driven in reset");

   // RQ7 amplifiers off in reset
   a_reset_fe_off : assert property (@(posedge CLK) // RQ7
      !RST_B |-> (!RX_SWITCH_EN && !RX_PAIR_PA_EN && !TX_PAIR_PA_EN))
      else $error("front end enabled in reset");

   // ---------------------------------------------------------------
   // Register and read port
   // ---------------------------------------------------------------
   // RQ15 write stores word
   a_write_stores : assert property (@(posedge CLK) disable iff (!RST_B) // RQ15
      wr_hit |=> (rf_control_b_reg == $past(REG_WDATA)))
      else $error("write to control word lost");

   // RQ15 no write, no change
   a_word_holds : assert property (@(posedge CLK) disable iff (!RST_B) // RQ15
      !wr_hit |=> $stable(rf_control_b_reg))
      else $error("control word changed without write");

   // RQ1 read answers held word
   a_read_word : assert property (@(posedge CLK) disable iff (!RST_B) // RQ1
      (REG_ADDR == rfsb_pkg::RF_CONTROL_B_ADDR) |=> (REG_RDATA == $past(rf_control_b_reg)))
      else $error("read data is not the control word");

   // RQ1 other addresses read zero
   a_read_other : assert property (@(posedge CLK) disable iff (!RST_B) // RQ1
      (REG_ADDR != rfsb_pkg::RF_CONTROL_B_ADDR) |=> (REG_RDATA == 16'h0000))
      else $error("unmapped address read not zero");

   // RQ15 enable lands two edges after strobe
   a_write_effect : assert property (@(posedge CLK) disable iff (!RST_B) // RQ15
      wr_hit |=> ##1 (BIAS_SWITCH_OUT_OE == $past(REG_WDATA[14], 2)))
      else $error("bias enable write not applied");

   // ---------------------------------------------------------------
   // Bias pin drive
   // ---------------------------------------------------------------
   // RQ9 tri-state while off
   a_tristate_when_off : assert property (@(posedge CLK) disable iff (!RST_B) // RQ9
      !ctrl.bias_en |=> !BIAS_SWITCH_OUT_OE) else $error("bias pin driven while disabled");

   // RQ9 level parked low while off
   a_low_when_off : assert property (@(posedge CLK) disable iff (!RST_B) // RQ9
      !BIAS_SWITCH_OUT_OE |-> !BIAS_SWITCH_OUT_O)
      else $error("bias level high while floating");

   // RQ10 driven while on
   a_drive_when_on : assert property (@(posedge CLK) disable iff (!RST_B) // RQ10
      ctrl.bias_en |=> BIAS_SWITCH_OUT_OE) else $error("bias pin not driven while enabled");

   // RQ6 high only in a sequence
   a_high_in_seq : assert property (@(posedge CLK) disable iff (!RST_B) // RQ6
      BIAS_SWITCH_OUT_O |-> $past(in_seq)) else $error("bias high outside sequence");

   // RQ14 low outside sequences
   a_idle_low : assert property (@(posedge CLK) disable iff (!RST_B) // RQ14
      !in_seq |=> !BIAS_SWITCH_OUT_O) else $error("bias not low when idle");

   // RQ14 idle drive is active low
   a_idle_driven_low : assert property (@(posedge CLK) disable iff (!RST_B) // RQ14
      (ctrl.bias_en && !in_seq) |=> (BIAS_SWITCH_OUT_OE && !BIAS_SWITCH_OUT_O))
      else $error("idle bias not driven low");

   // ---------------------------------------------------------------
   // Single-port mode
   // ---------------------------------------------------------------
   // RQ5 transmit drives high
   a_single_tx_high : assert property (@(posedge CLK) disable iff (!RST_B) // RQ5
      (ctrl.bias_en && ctrl.single_port && is_tx) |=> BIAS_SWITCH_OUT_O)
      else $error("single-port tx bias not high");

   // RQ5 receive drives low whatever the polarity
   a_single_rx_bias : assert property (@(posedge CLK) disable iff (!RST_B) // RQ5
      (ctrl.bias_en && ctrl.single_port && is_rx) |=> !BIAS_SWITCH_OUT_O)
      else $error("single-port rx bias not low");

   // RQ11 polarity ignored in single-port
   a_single_no_pol : assert property (@(posedge CLK) disable iff (!RST_B) // RQ11
      (ctrl.bias_en && ctrl.single_port && in_seq)
      |=> (BIAS_SWITCH_OUT_O == ($past(RADIO_OP) == rfsb_pkg::RFSB_TX)))
      else $error("single-port bias follows polarity");

   // RQ3 receive switch on, pair amplifier off
   a_single_rx_low : assert property (@(posedge CLK) disable iff (!RST_B) // RQ3
      (ctrl.single_port && is_rx) |=> (RX_SWITCH_EN && !RX_PAIR_PA_EN && !BIAS_SWITCH_OUT_O))
      else $error("single-port rx controls wrong");

   // RQ4 transmit isolates the amplifier input
   a_single_tx_en : assert property (@(posedge CLK) disable iff (!RST_B) // RQ4
      (ctrl.single_port && is_tx) |=> (!RX_SWITCH_EN && RX_PAIR_PA_EN && !TX_PAIR_PA_EN))
      else $error("single-port tx controls wrong");

   // RQ4 switch and pair amplifier never both on
   a_switch_pa_excl : assert property (@(posedge CLK) disable iff (!RST_B) // RQ4
      !(RX_SWITCH_EN && RX_PAIR_PA_EN))
      else $error("rx switch on while pair amplifier on");

   // RQ2 tx pair unused in single-port
   a_single_tx_pair_off : assert property (@(posedge CLK) disable iff (!RST_B) // RQ2
      ctrl.single_port |=> !TX_PAIR_PA_EN)
      else $error("tx pair amplifier on in single-port");

   // RQ2 pair direction tracks its amplifier
   a_dir_tracks_pa : assert property (@(posedge CLK) disable iff (!RST_B) // RQ2
      RX_PAIR_DIR_OUT == RX_PAIR_PA_EN)
      else $error("rx pair direction disagrees with amplifier");

   // ---------------------------------------------------------------
   // Dual-port mode
   // ---------------------------------------------------------------
   // RQ7 rx pair amplifier stays off
   a_dual_rx_pa_off : assert property (@(posedge CLK) disable iff (!RST_B) // RQ7
      !ctrl.single_port |=> !RX_PAIR_PA_EN) else $error("dual-port rx pair amplifier on");

   // RQ7 rx pair input only
   a_dual_dir_in : assert property (@(posedge CLK) disable iff (!RST_B) // RQ7
      !ctrl.single_port |=> !RX_PAIR_DIR_OUT)
      else $error("dual-port rx pair driven");

   // RQ7 switch on for receive
   a_dual_rx_switch : assert property (@(posedge CLK) disable iff (!RST_B) // RQ7
      (!ctrl.single_port && is_rx) |=> RX_SWITCH_EN)
      else $error("dual-port rx switch off");

   // RQ8 tx pair carries transmit
   a_dual_tx_pair : assert property (@(posedge CLK) disable iff (!RST_B) // RQ8
      (!ctrl.single_port && is_tx) |=> TX_PAIR_PA_EN) else $error("dual-port tx pair off");

   // RQ8 the two amplifiers never both on
   a_pa_exclusive : assert property (@(posedge CLK) disable iff (!RST_B) // RQ8
      !(RX_PAIR_PA_EN && TX_PAIR_PA_EN))
      else $error("both amplifiers on");

   // RQ12 receive level is the polarity bit
   a_dual_rx_level : assert property (@(posedge CLK) disable iff (!RST_B) // RQ12
      (ctrl.bias_en && !ctrl.single_port && is_rx)
      |=> (BIAS_SWITCH_OUT_O == $past(ctrl.polarity)))
      else $error("dual-port rx bias level wrong");

   // RQ12 transmit level is the inverse
   a_dual_tx_level : assert property (@(posedge CLK) disable iff (!RST_B) // RQ12
      (ctrl.bias_en && !ctrl.single_port && is_tx)
      |=> (BIAS_SWITCH_OUT_O == !$past(ctrl.polarity)))
      else $error("dual-port tx bias level wrong");

   // RQ13 polarity flips the sense
   a_dual_polarity : assert property (@(posedge CLK) disable iff (!RST_B) // RQ13
      (ctrl.bias_en && !ctrl.single_port && in_seq)
      |=> (BIAS_SWITCH_OUT_O
           == (($past(RADIO_OP) == rfsb_pkg::RFSB_TX) != $past(ctrl.polarity))))
      else $error("dual-port bias sense wrong");

   // Limitation: a control write in mid-sequence is obeyed at once, so
   // the host keeps the bits steady while the radio is busy.

endmodule
`default_nettype wire

// ==== rtl/rfsb_pkg.sv ====
// Package for the RF port switch and bias control block
`default_nettype none
package rfsb_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [5:0]  RF_CONTROL_B_ADDR = 6'h07;
   localparam logic [15:0] RF_CONTROL_B_RST  = 16'h0000;
   localparam int          PORT_MODE_POS     = 12;
   localparam int          POLARITY_POS      = 13;
   localparam int          BIAS_EN_POS       = 14;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   // Radio activity as seen by the front end
   typedef enum logic [2:0] {
      RFSB_IDLE,
      RFSB_DOZE,
      RFSB_HIBERNATE,
      RFSB_CCA,
      RFSB_RX,
      RFSB_TX
   } rfsb_op_t;

   // Control bits held from the register
   typedef struct packed {
      logic bias_en;
      logic polarity;
      logic single_port;
   } rfsb_ctrl_t;

   // Front end enables and bias pin drive
   typedef struct packed {
      logic rx_switch_en;
      logic rx_pair_pa_en;
      logic tx_pair_pa_en;
      logic bias_out;
      logic bias_oe;
   } rfsb_fe_t;
endpackage
`default_nettype wire

// ==== test/rfsb_fe_model.sv ====
// Behavioural model of the balun or antenna switch on the bias pin
`default_nettype none
module rfsb_fe_model (
   // Bias pin from the block
   input  wire logic bias_o,
   input  wire logic bias_oe,
   // What the load sees
   output logic      pin_hiz
);
   timeunit 1ns;
   timeprecision 1ns;
   wire bias_pin;
   // No pull on this node, so an undriven pin really floats
   assign bias_pin = bias_oe ? bias_o : 1'bz;
   // Load senses a floating pin
   assign pin_hiz  = (bias_pin === 1'bz);
endmodule
`default_nettype wire

// ==== test/rf_port_switch_bias_control_tb_top.sv ====
// Self-checking testbench for the RF port switch and bias control block
`default_nettype none
module rf_port_switch_bias_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic               CLK, RST_B, we, dir;
   logic [5:0]         addr;
   logic [15:0]        wdata, rdata;
   rfsb_pkg::rfsb_op_t op;
   rfsb_pkg::rfsb_fe_t got;
   wire logic          pin_hiz;
   int                 failures, cmp_count;
   rfsb_ctrl rfsb_ctrl_i (.CLK(CLK), .RST_B(RST_B), .REG_WE(we), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .RADIO_OP(op),
      .RX_SWITCH_EN(got.rx_switch_en), .RX_PAIR_PA_EN(got.rx_pair_pa_en),
      .TX_PAIR_PA_EN(got.tx_pair_pa_en), .RX_PAIR_DIR_OUT(dir),
      .BIAS_SWITCH_OUT_O(got.bias_out), .BIAS_SWITCH_OUT_OE(got.bias_oe));
   rfsb_fe_model rfsb_fe_model_i (.bias_o(got.bias_out), .bias_oe(got.bias_oe),
      .pin_hiz(pin_hiz));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] act);
      cmp_count++;
      if (act !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, act);
      end
   endtask
   // Strobe held one cycle; the write lands on the edge where the task ends
   task automatic wr(logic [5:0] a, logic [15:0] d);
      @(posedge CLK);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge CLK);
      we <= 1'b0;
   endtask
   task automatic rd(logic [5:0] a, logic [15:0] exp);
      @(posedge CLK);
      addr <= a;
      @(posedge CLK);
      #1 chk("rdata", exp, rdata);
   endtask
   // Expected front end from control bits {en,pol,single} and radio activity
   function automatic logic [4:0] exp_fe(logic [2:0] c, rfsb_pkg::rfsb_op_t o);
      logic tx, rx, lvl;
      tx = (o == rfsb_pkg::RFSB_TX);
      rx = (o == rfsb_pkg::RFSB_RX) || (o == rfsb_pkg::RFSB_CCA);
      lvl = tx ? (c[0] | ~c[1]) : (rx & ~c[0] & c[1]);
      return {rx, c[0] & tx, ~c[0] & tx, c[2] & lvl, c[2]};
   endfunction
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd(6'h07, 16'h0000);
      chk("hiz", 16'h1, {15'h0, pin_hiz});
   endtask
   // Output follows one edge after the write edge, not the same one
   task automatic t_latency();
      wr(6'h07, 16'h4000);
      #1 chk("oe_early", 16'h0, {15'h0, got.bias_oe});
      @(posedge CLK);
      #1 chk("oe_late", 16'h1, {15'h0, got.bias_oe});
   endtask
   // Every control combination against every radio activity
   task automatic t_table();
      for (int c = 0; c < 8; c++) begin
         wr(6'h07, {1'b0, c[2:0], 12'h000});
         // bits set while idle, before activity
         for (int k = 0; k < 6; k++) begin
            @(posedge CLK);
            op <= rfsb_pkg::rfsb_op_t'(k);
            @(posedge CLK);
            #1 chk("fe", {11'h0, exp_fe(c[2:0], op)}, {11'h0, got});
            chk("dir", {15'h0, c[0] & (k == 5)}, {15'h0, dir});
            chk("hiz", {15'h0, ~c[2]}, {15'h0, pin_hiz});
         end
         // back to idle before the next write
         @(posedge CLK);
         op <= rfsb_pkg::RFSB_IDLE;
      end
   endtask
   // Whole word kept; other addresses neither stored nor read back
   task automatic t_unmapped();
      wr(6'h07, 16'hA5C3);
      wr(6'h06, 16'h0000);
      rd(6'h07, 16'hA5C3);
      rd(6'h06, 16'h0000);
   endtask
   task automatic summarize();
      if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Clock, sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   initial begin
      RST_B = 1'b0;
      we = 1'b0;
      addr = 6'h00;
      wdata = 16'h0000;
      op = rfsb_pkg::RFSB_IDLE;
      repeat (8) @(posedge CLK);
      RST_B <= 1'b1;
      t_reset();
      t_latency();
      t_table();
      t_unmapped();
      summarize();
   end
   // Run needs about 150 cycles; allow far more
   initial begin
      #200000;
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
